// *** hdl/uic_top.sv ***
// uart register slice: divisor high byte, interrupt identity, fifo control
`timescale 1ns/1ps
module uic_top (
   // clock, power-on reset, soft reset
   input  wire logic                   clk_sys,
   input  wire logic                   resetn,
   input  wire logic                   sw_resetn,
   // register port
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   input  wire logic [2:0]             reg_addr,
   input  wire logic [7:0]             reg_wdata,
   output logic      [7:0]             reg_rdata,
   // interrupt sources from the channel
   input  wire logic                   line_err,
   input  wire logic                   rx_timeout,
   input  wire logic                   modem_chg,
   input  wire logic                   pin_chg,
   // receiver side
   input  wire logic                   rx_push,
   input  wire logic [7:0]             rx_char,
   // transmitter side
   input  wire logic                   tx_pop,
   output logic      [7:0]             tx_char,
   output logic                        tx_avail,
   // status
   output logic      [15:0]            divisor,
   output logic                        irq,
   output logic                        fifo_enable,
   output logic                        sleep_allow,
   output logic      [uic_pkg::CNT_W-1:0] tx_level,
   output logic      [uic_pkg::CNT_W-1:0] rx_level
);
   import uic_pkg::*;

   typedef struct packed {
      logic [7:0] line_control;
      logic [7:0] enhanced_feature;
      logic [7:0] interrupt_enable_bits;
      logic [7:0] dll;
      logic [7:0] divisor_high_byte;
      logic       fen;
      logic [1:0] rx_trig;
      logic [1:0] tx_trig;
      logic       tx_clr;
      logic       rx_clr;
      logic [7:0] rdata;
      logic       irq;
      logic       slp;
   } uic_st_t;

   localparam uic_st_t ST_RST = '{line_control: LCR_RST, enhanced_feature: 8'h00, interrupt_enable_bits: 8'h00,
      dll: DLL_RST, divisor_high_byte: DLH_RST, fen: 1'b0, rx_trig: 2'h0, tx_trig: 2'h0,
      tx_clr: 1'b0, rx_clr: 1'b0, rdata: 8'h00, irq: 1'b0, slp: 1'b0};

   uic_st_t          s;
   uic_st_t          next_s;
   logic             key;
   logic             dlab;
   logic             enh;
   logic             thr_push;
   logic             rhr_pop;
   logic             tx_full;
   logic             rx_full;
   logic [CNT_W-1:0] tx_cnt;
   logic [CNT_W-1:0] rx_cnt;
   logic [CNT_W-1:0] cap;
   logic [CNT_W-1:0] rx_lvl;
   logic [CNT_W-1:0] tx_lvl;
   logic [5:0]       req;
   logic [5:0]       iir_lo;
   logic [7:0]       interrupt_identity;
   logic [7:0]       rx_head;

   // trigger decode, shared shape for both directions
   function automatic logic [CNT_W-1:0] lvl(input logic [1:0] sel,
                                            input logic [CNT_W-1:0] l0,
                                            input logic [CNT_W-1:0] l1,
                                            input logic [CNT_W-1:0] l2,
                                            input logic [CNT_W-1:0] l3);
      case (sel)
         2'h0:    lvl = l0;
         2'h1:    lvl = l1;
         2'h2:    lvl = l2;
         default: lvl = l3;
      endcase
   endfunction

   // highest priority pending request wins; bit 0 low means pending
   function automatic logic [5:0] encode(input logic [5:0] r);
      if (r[0])      encode = {ID_LSE, 1'b0};
      else if (r[1]) encode = {ID_TMO, 1'b0};
      else if (r[2]) encode = {ID_RXD, 1'b0};
      else if (r[3]) encode = {ID_THR, 1'b0};
      else if (r[4]) encode = {ID_MSR, 1'b0};
      else if (r[5]) encode = {ID_PIN, 1'b0};
      else           encode = 6'h01;
   endfunction

   assign key      = s.line_control == LCR_EFR_KEY;
   assign dlab     = s.line_control[LCR_DLAB];
   assign enh      = s.enhanced_feature[EFR_ENH];
   assign thr_push = reg_wr && reg_addr == OFF_DATA && !dlab;
   assign rhr_pop  = reg_rd && reg_addr == OFF_DATA && !dlab;

   // disabled fifos fall back to a one-character trigger
   assign cap    = s.fen ? CNT_W'(FIFO_DEPTH) : LVL_ONE;
   assign rx_lvl = s.fen ? lvl(s.rx_trig, RX_LVL0, RX_LVL1, RX_LVL2, RX_LVL3)
                         : LVL_ONE;
   assign tx_lvl = s.fen ? lvl(s.tx_trig, TX_LVL0, TX_LVL1, TX_LVL2, TX_LVL3)
                         : LVL_ONE;

   // enabled sources in priority order; pin change needs enhanced mode
   assign req[0] = s.interrupt_enable_bits[IER_LSE] && line_err;
   assign req[1] = s.interrupt_enable_bits[IER_RXD] && rx_timeout;
   assign req[2] = s.interrupt_enable_bits[IER_RXD] && rx_cnt >= rx_lvl;
   assign req[3] = s.interrupt_enable_bits[IER_THR] && (cap - tx_cnt) >= tx_lvl;
   assign req[4] = s.interrupt_enable_bits[IER_MSR] && modem_chg;
   assign req[5] = enh && pin_chg;
   assign iir_lo = encode(req);
   assign interrupt_identity    = {s.fen, s.fen, iir_lo};

   // register writes, readback and soft reset
   always_comb begin
      next_s        = s;
      next_s.tx_clr = 1'b0;
      next_s.rx_clr = 1'b0;
      next_s.irq    = !iir_lo[0];
      if (reg_wr) begin
         case (reg_addr)
            OFF_DATA: begin
               if (dlab && !key) next_s.dll = reg_wdata;
            end
            OFF_IER: begin
               if (dlab && !key) begin
                  next_s.divisor_high_byte = reg_wdata;
               end else if (!dlab) begin
                  next_s.interrupt_enable_bits[3:0] = reg_wdata[3:0];
                  if (enh) next_s.interrupt_enable_bits[7:4] = reg_wdata[7:4];
               end
            end
            OFF_IIR: begin
               if (key) begin
                  next_s.enhanced_feature = reg_wdata;
               end else begin
                  next_s.fen = reg_wdata[FCR_EN];
                  if (reg_wdata[FCR_EN]) begin
                     // a write that keeps fifos off changes nothing else
                     next_s.rx_trig = reg_wdata[7:6];
                     if (enh) next_s.tx_trig = reg_wdata[5:4];
                     next_s.tx_clr = reg_wdata[FCR_TXC] || !s.fen;
                     next_s.rx_clr = reg_wdata[FCR_RXC] || !s.fen;
                  end else if (s.fen) begin
                     // leaving fifo mode drops stale contents
                     next_s.tx_clr = 1'b1;
                     next_s.rx_clr = 1'b1;
                  end
               end
            end
            OFF_LCR: next_s.line_control = reg_wdata;
            default: ;
         endcase
      end
      next_s.rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            OFF_DATA: next_s.rdata = dlab ? s.dll : (rx_cnt != '0) ? rx_head : 8'h00;
            OFF_IER:  next_s.rdata = dlab ? s.divisor_high_byte : s.interrupt_enable_bits;
            OFF_IIR:  next_s.rdata = key ? s.enhanced_feature : interrupt_identity;
            OFF_LCR:  next_s.rdata = s.line_control;
            default:  next_s.rdata = 8'h00;
         endcase
      end
      if (!sw_resetn) begin
         // divisor survives every reset but power-on
         next_s        = ST_RST;
         next_s.dll    = s.dll;
         next_s.divisor_high_byte    = s.divisor_high_byte;
         // fifos fall back to one entry, so stale contents must go
         next_s.tx_clr = s.fen;
         next_s.rx_clr = s.fen;
      end
      // kept in a flop so the pin has no gate behind it
      next_s.slp = next_s.interrupt_enable_bits[IER_SLP] && next_s.enhanced_feature[EFR_ENH];
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         s <= ST_RST;
      end else begin
         s <= next_s;
      end
   end

   uic_fifo #(.W(8), .D(FIFO_DEPTH)) u_tx (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .clear   (s.tx_clr),
      .enable  (s.fen),
      .push    (thr_push),
      .din     (reg_wdata),
      .pop     (tx_pop),
      .dout    (tx_char),
      .count   (tx_cnt),
      .full    (tx_full)
   );

   uic_fifo #(.W(8), .D(FIFO_DEPTH)) u_rx (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .clear   (s.rx_clr),
      .enable  (s.fen),
      .push    (rx_push),
      .din     (rx_char),
      .pop     (rhr_pop),
      .dout    (rx_head),
      .count   (rx_cnt),
      .full    (rx_full)
   );

   assign reg_rdata   = s.rdata;
   assign divisor     = {s.divisor_high_byte, s.dll};
   assign irq         = s.irq;
   assign fifo_enable = s.fen;
   assign sleep_allow = s.slp;
   assign tx_avail    = tx_cnt != '0;
   assign tx_level    = tx_cnt;
   assign rx_level    = rx_cnt;

   // checks
   property p_div_keep;
      @(posedge clk_sys) disable iff (!resetn)
      !sw_resetn |=> divisor == $past(divisor);
   endproperty
   a_div_keep: assert property (p_div_keep) else $error("divisor lost on soft reset");

   property p_dlh_wr;
      @(posedge clk_sys) disable iff (!resetn)
      reg_wr && sw_resetn && reg_addr == OFF_IER && dlab && !key
         |=> divisor[15:8] == $past(reg_wdata);
   endproperty
   a_dlh_wr: assert property (p_dlh_wr) else $error("divisor high byte not written");

   property p_idle_bit;
      @(posedge clk_sys) disable iff (!resetn)
      reg_rd && sw_resetn && reg_addr == OFF_IIR && !key |=> reg_rdata[0] == ($past(req) == 6'h00);
   endproperty
   a_idle_bit: assert property (p_idle_bit) else $error("identity pending bit wrong");

   property p_lse_first;
      @(posedge clk_sys) disable iff (!resetn)
      reg_rd && sw_resetn && reg_addr == OFF_IIR && !key && req[0]
         |=> reg_rdata[5:0] == 6'h06;
   endproperty
   a_lse_first: assert property (p_lse_first) else $error("line error not on top");

   property p_tx_clear;
      @(posedge clk_sys) disable iff (!resetn)
      reg_wr && sw_resetn && reg_addr == OFF_IIR && !key && (reg_wdata & 8'h05) == 8'h05
         |=> s.tx_clr ##1 (!s.tx_clr && tx_level == 7'h00);
   endproperty
   a_tx_clear: assert property (p_tx_clear) else $error("tx fifo not cleared");

   property p_rx_clear;
      @(posedge clk_sys) disable iff (!resetn)
      reg_wr && sw_resetn && reg_addr == OFF_IIR && !key && (reg_wdata & 8'h03) == 8'h03
         |=> s.rx_clr ##1 (!s.rx_clr && rx_level == 7'h00);
   endproperty
   a_rx_clear: assert property (p_rx_clear) else $error("rx fifo not cleared");

   property p_one_char;
      @(posedge clk_sys) disable iff (!resetn)
      !s.fen && !$past(s.fen) |-> tx_level <= 7'h01 && rx_level <= 7'h01;
   endproperty
   a_one_char: assert property (p_one_char) else $error("disabled fifo over one");

   property p_full_drop;
      @(posedge clk_sys) disable iff (!resetn)
      thr_push && tx_full && !tx_pop && !s.tx_clr |=> tx_level == $past(tx_level);
   endproperty
   a_full_drop: assert property (p_full_drop) else $error("write to full fifo kept");

   property p_txtrig_lock;
      @(posedge clk_sys) disable iff (!resetn)
      reg_wr && sw_resetn && reg_addr == OFF_IIR && !key && !enh |=> $stable(s.tx_trig);
   endproperty
   a_txtrig_lock: assert property (p_txtrig_lock) else $error("tx trigger changed");

   property p_ier_lock;
      @(posedge clk_sys) disable iff (!resetn)
      reg_wr && sw_resetn && reg_addr == OFF_IER && !dlab && !enh |=> $stable(s.interrupt_enable_bits[7:4]);
   endproperty
   a_ier_lock: assert property (p_ier_lock) else $error("upper enables changed");

   c_irq:   cover property (@(posedge clk_sys) disable iff (!resetn) $rose(irq));
   c_full:  cover property (@(posedge clk_sys) disable iff (!resetn) s.fen && tx_full);
   c_clear: cover property (@(posedge clk_sys) disable iff (!resetn) s.tx_clr && s.rx_clr);
endmodule

// *** hdl/uic_pkg.sv ***
// constants for the uart interrupt identity and fifo control block
// Function
// - identity bit 0 reads 1 when nothing pending, else 0.
// - source codes: line error 0110, timeout 1100, rx data 0100, tx 0010, modem 0000.
// - pin change source reported through identity code, ranked below modem status.
// - fifo control bits 7:6 pick rx trigger 8, 16, 56 or 60 characters.
// - fifo control bits 5:4 pick tx trigger 8, 16, 32 or 56 spaces.
// - fifo control bit 2 empties tx fifo, keeps shift register, self-clears.
// - fifo control bit 1 empties rx fifo, keeps shift register, self-clears.
// - fifo enable low makes transmitter and receiver hold one character each.
// - fifos disabled: other fifo control bits ignored, trigger level one character.
// - fifo enable high gives 64 character tx and rx fifos.
// - tx trigger field written only while enhanced enable is set, but used whenever fifos are enabled.
// - upper four interrupt enable bits written only while enhanced enable set.
// - line control bit 7 maps divisor bytes over holding and enable registers.
// - enhanced enable gates extended enable, identity, tx trigger bits and sleep permission.
// - byte written to transmit holding while tx fifo full is dropped.
package uic_pkg;
   // register offsets on the serial register port
   localparam logic [2:0] OFF_DATA = 3'h0;
   localparam logic [2:0] OFF_IER  = 3'h1;
   localparam logic [2:0] OFF_IIR  = 3'h2;
   localparam logic [2:0] OFF_LCR  = 3'h3;
   // field positions
   localparam int LCR_DLAB = 7;
   localparam int EFR_ENH  = 4;
   localparam int IER_RXD  = 0;
   localparam int IER_THR  = 1;
   localparam int IER_LSE  = 2;
   localparam int IER_MSR  = 3;
   localparam int IER_SLP  = 4;
   localparam int FCR_EN   = 0;
   localparam int FCR_RXC  = 1;
   localparam int FCR_TXC  = 2;
   // reset values and access key
   localparam logic [7:0] LCR_RST      = 8'h1D;
   localparam logic [7:0] LCR_EFR_KEY  = 8'hBF;
   localparam logic [7:0] DLL_RST      = 8'h01;
   localparam logic [7:0] DLH_RST      = 8'h00;
   // identity codes, bits 5:1
   localparam logic [4:0] ID_LSE  = 5'h03;
   localparam logic [4:0] ID_TMO  = 5'h06;
   localparam logic [4:0] ID_RXD  = 5'h02;
   localparam logic [4:0] ID_THR  = 5'h01;
   localparam logic [4:0] ID_MSR  = 5'h00;
   localparam logic [4:0] ID_PIN  = 5'h10;
   // fifo sizes and trigger levels
   localparam int FIFO_DEPTH = 64;
   localparam int CNT_W      = 7;
   localparam logic [6:0] RX_LVL0 = 7'h08;
   localparam logic [6:0] RX_LVL1 = 7'h10;
   localparam logic [6:0] RX_LVL2 = 7'h38;
   localparam logic [6:0] RX_LVL3 = 7'h3C;
   localparam logic [6:0] TX_LVL0 = 7'h08;
   localparam logic [6:0] TX_LVL1 = 7'h10;
   localparam logic [6:0] TX_LVL2 = 7'h20;
   localparam logic [6:0] TX_LVL3 = 7'h38;
   localparam logic [6:0] LVL_ONE = 7'h01;
endpackage

// *** hdl/uic_fifo.sv ***
// character fifo with clear, one-entry mode when disabled
`timescale 1ns/1ps
module uic_fifo #(
   parameter int W = 8,
   parameter int D = 64
) (
   // clock and reset
   input  wire logic                   clk_sys,
   input  wire logic                   resetn,
   // control
   input  wire logic                   clear,
   input  wire logic                   enable,
   // write side
   input  wire logic                   push,
   input  wire logic [W-1:0]           din,
   // read side
   input  wire logic                   pop,
   output logic      [W-1:0]           dout,
   output logic      [$clog2(D):0]     count,
   output logic                        full
);
   localparam int AW = $clog2(D);
   localparam int CW = AW + 1;

   if (D < 2 || (D & (D - 1)) != 0) begin : g_bad_depth
      $error("fifo depth must be a power of two of at least 2");
   end

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic [CW-1:0]       cnt;
   } uic_fifo_st_t;

   uic_fifo_st_t s;
   uic_fifo_st_t next_s;
   logic         do_push;
   logic         do_pop;
   logic [CW-1:0] cap;

   // disabled fifo holds a single character
   assign cap     = enable ? CW'(D) : CW'(1);
   assign full    = s.cnt >= cap;
   assign do_push = push && !full;
   assign do_pop  = pop && (s.cnt != '0);
   assign dout    = s.mem[s.rp];
   assign count   = s.cnt;

   // clear drops pointers and count only; the shift register outside is untouched
   always_comb begin
      next_s = s;
      if (clear) begin
         next_s.wp  = '0;
         next_s.rp  = '0;
         next_s.cnt = '0;
      end else begin
         if (do_push) begin
            next_s.mem[s.wp] = din;
            next_s.wp        = s.wp + 1'b1;
         end
         if (do_pop) begin
            next_s.rp = s.rp + 1'b1;
         end
         next_s.cnt = s.cnt + CW'(do_push) - CW'(do_pop);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule

// *** tb/uic_host_model.sv ***
// host processor model that drives the serial register port
`timescale 1ns/1ps
module uic_host_model (
   // clock
   input  wire logic       clk_sys,
   // register port
   output logic            reg_wr,
   output logic            reg_rd,
   output logic [2:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   // strobes idle from time zero so nothing is taken while reset is held
   initial begin
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 3'h7;
      reg_wdata = 8'hFF;
   end

   // one-cycle write pulse; released lines show the inverse so stale data never matches
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
      // let the taking edge settle before the caller looks at outputs
      #1;
   endtask

   // one-cycle read pulse; data stands only in the cycle after the taking edge
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = reg_rdata;
   endtask
endmodule

// *** tb/tb_uart_irq_id_and_fifo_control.sv ***
// self-checking bench for the uart identity and fifo control slice
`timescale 1ns/1ps
module tb_uart_irq_id_and_fifo_control;
   import uic_pkg::*;
   // clock, resets, register port and channel side
   logic                clk_sys;
   logic                resetn;
   logic                sw_resetn;
   logic                reg_wr;
   logic                reg_rd;
   logic [2:0]          reg_addr;
   logic [7:0]          reg_wdata;
   logic [7:0]          reg_rdata;
   logic                line_err;
   logic                rx_timeout;
   logic                modem_chg;
   logic                pin_chg;
   logic                rx_push;
   logic [7:0]          rx_char;
   logic                tx_pop;
   logic [7:0]          tx_char;
   logic                tx_avail;
   logic [15:0]         divisor;
   logic                irq;
   logic                fifo_enable;
   logic                sleep_allow;
   logic [CNT_W-1:0]    tx_level;
   logic [CNT_W-1:0]    rx_level;
   int                  failures;
   int                  samples_checked;
   logic [6:0]          rx_lvl [4];
   logic [6:0]          tx_lvl [4];

   // 250 MHz system clock
   initial clk_sys = 1'b0;
   always #2 clk_sys = ~clk_sys;

   uic_top DUT (.clk_sys(clk_sys), .resetn(resetn), .sw_resetn(sw_resetn), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .line_err(line_err), .rx_timeout(rx_timeout), .modem_chg(modem_chg), .pin_chg(pin_chg),
      .rx_push(rx_push), .rx_char(rx_char), .tx_pop(tx_pop), .tx_char(tx_char),
      .tx_avail(tx_avail), .divisor(divisor), .irq(irq), .fifo_enable(fifo_enable),
      .sleep_allow(sleep_allow), .tx_level(tx_level), .rx_level(rx_level));

   uic_host_model u_host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

   // compare, count, report
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wrap_up;
      if (failures == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // read a register through the host and compare the byte
   task automatic rd_chk(input string what, input logic [2:0] a, input logic [7:0] exp);
      logic [7:0] v;
      u_host.rd(a, v);
      chk(what, {8'h00, exp}, {8'h00, v});
   endtask

   // causes are levels; irq follows one cycle later, so let two edges pass
   task automatic set_causes(input logic l, input logic t, input logic m, input logic p);
      @(posedge clk_sys);
      line_err   <= l;
      rx_timeout <= t;
      modem_chg  <= m;
      pin_chg    <= p;
      repeat (2) @(posedge clk_sys);
   endtask

   task automatic push_rx(input int n);
      repeat (n) begin
         @(posedge clk_sys);
         rx_push <= 1'b1;
         rx_char <= 8'h3C;
         @(posedge clk_sys);
         rx_push <= 1'b0;
      end
      // counts move at the last edge; look once they have settled
      #1;
   endtask

   task automatic push_tx(input int n);
      repeat (n) u_host.wr(3'h0, 8'hA7);
   endtask

   // the enhanced bank opens only with the access key in line control
   task automatic enh(input logic on);
      u_host.wr(3'h3, 8'hBF);
      u_host.wr(3'h2, on ? 8'h10 : 8'h00);
      u_host.wr(3'h3, 8'h03);
   endtask

   task automatic t_reset_values;
      rd_chk("identity", 3'h2, 8'h01);
      chk("divisor", 16'h0001, divisor);
   endtask

   task automatic t_divisor;
      u_host.wr(3'h3, 8'h80);
      u_host.wr(3'h1, 8'hA5);
      chk("divisor", 16'hA501, divisor);
      @(posedge clk_sys);
      sw_resetn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      sw_resetn <= 1'b1;
      @(posedge clk_sys);
      chk("divisor", 16'hA501, divisor);
   endtask

   // all four causes up, then drop them one by one from the top
   task automatic t_priority;
      enh(1'b1);
      u_host.wr(3'h1, 8'h1F);
      chk("sleep_allow", 16'h0001, {15'h0000, sleep_allow});
      u_host.wr(3'h2, 8'h01);
      set_causes(1'b1, 1'b1, 1'b1, 1'b1);
      rd_chk("identity", 3'h2, {2'b11, ID_LSE, 1'b0});
      chk("irq", 16'h0001, {15'h0000, irq});
      set_causes(1'b0, 1'b1, 1'b1, 1'b1);
      rd_chk("identity", 3'h2, {2'b11, ID_TMO, 1'b0});
      set_causes(1'b0, 1'b0, 1'b1, 1'b1);
      rd_chk("identity", 3'h2, 8'hC2);
      push_tx(57);
      rd_chk("identity", 3'h2, {2'b11, ID_MSR, 1'b0});
      set_causes(1'b0, 1'b0, 1'b0, 1'b1);
      rd_chk("identity", 3'h2, {2'b11, ID_PIN, 1'b0});
      set_causes(1'b0, 1'b0, 1'b0, 1'b0);
      rd_chk("identity", 3'h2, 8'hC1);
      push_tx(8);
      chk("tx_level", 16'd64, {9'h000, tx_level});
   endtask

   task automatic t_rx_trig;
      for (int k = 0; k < 4; k++) begin
         u_host.wr(3'h2, {k[1:0], 6'b000011});
         repeat (3) @(posedge clk_sys);
         chk("rx_level", 16'h0000, {9'h000, rx_level});
         chk("tx_level", 16'd64, {9'h000, tx_level});
         push_rx(int'(rx_lvl[k]) - 1);
         rd_chk("identity", 3'h2, 8'hC1);
         push_rx(1);
         rd_chk("identity", 3'h2, {2'b11, ID_RXD, 1'b0});
      end
   endtask

   task automatic t_tx_trig;
      for (int k = 0; k < 4; k++) begin
         u_host.wr(3'h2, {2'b00, k[1:0], 4'b0111});
         repeat (3) @(posedge clk_sys);
         chk("tx_level", 16'h0000, {9'h000, tx_level});
         push_tx(FIFO_DEPTH - int'(tx_lvl[k]));
         rd_chk("identity", 3'h2, 8'hC2);
         push_tx(1);
         rd_chk("identity", 3'h2, 8'hC1);
      end
   endtask

   // with the enhanced bit off, the upper enables and the tx trigger stay as they were
   task automatic t_enh_gate;
      enh(1'b0);
      u_host.wr(3'h1, 8'hFF);
      rd_chk("enables", 3'h1, 8'h1F);
      chk("sleep_allow", 16'h0000, {15'h0000, sleep_allow});
      u_host.wr(3'h2, 8'h07);
      repeat (3) @(posedge clk_sys);
      push_tx(9);
      rd_chk("identity", 3'h2, 8'hC1);
   endtask

   task automatic t_disabled;
      u_host.wr(3'h2, 8'h00);
      repeat (3) @(posedge clk_sys);
      chk("fifo_enable", 16'h0000, {15'h0000, fifo_enable});
      rd_chk("identity", 3'h2, 8'h02);
      u_host.wr(3'h0, 8'h5A);
      u_host.wr(3'h0, 8'h66);
      chk("tx_level", 16'h0001, {9'h000, tx_level});
      chk("tx_char", 16'h005A, {8'h00, tx_char});
      rd_chk("identity", 3'h2, 8'h01);
      u_host.wr(3'h2, 8'hC0);
      push_rx(2);
      chk("rx_level", 16'h0001, {9'h000, rx_level});
      rd_chk("identity", 3'h2, 8'h04);
      rd_chk("rx_data", 3'h0, 8'h3C);
      @(posedge clk_sys);
      tx_pop <= 1'b1;
      @(posedge clk_sys);
      tx_pop <= 1'b0;
      @(posedge clk_sys);
      chk("tx_avail", 16'h0000, {15'h0000, tx_avail});
   endtask

   task automatic t_power_reset;
      @(posedge clk_sys);
      resetn <= 1'b0;
      repeat (8) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      chk("divisor", 16'h0001, divisor);
   endtask

   // main sequence: every input valued at time zero, reset for 8 cycles
   initial begin
      rx_lvl = '{RX_LVL0, RX_LVL1, RX_LVL2, RX_LVL3};
      tx_lvl = '{TX_LVL0, TX_LVL1, TX_LVL2, TX_LVL3};
      failures = 0;
      samples_checked = 0;
      resetn = 1'b0;
      sw_resetn = 1'b1;
      {line_err, rx_timeout, modem_chg, pin_chg, rx_push, tx_pop} = 6'h00;
      rx_char = 8'h00;
      repeat (8) @(posedge clk_sys);
      resetn <= 1'b1;
      t_reset_values();
      t_divisor();
      t_priority();
      t_rx_trig();
      t_tx_trig();
      t_enh_gate();
      t_disabled();
      t_power_reset();
      wrap_up();
   end

   // the run needs about a thousand cycles; this limit of 50000 cycles is far beyond that
   initial begin
      #200000;
      failures++;
      wrap_up();
   end
endmodule
